// ===== rtl/port_pin_function_select.sv
// Pin function multiplexer for port two pin 7 and ports three and four.
//
// Notes on behaviour
// [RL1] Select 0 and no analog enable: general I/O, direction bit picks in or out.
// [RL2] Port two pin 7 resets to crystal output; clearing select gives general I/O.
// [RL3] Port three pin 0 with select 1 joins serial block; serial block sets direction.
// [RL4] Port three pin 0: serial A clock beats B slave enable; B forced 3-wire.
// [RL5] Port three pin 3: serial B clock beats A slave enable; A forced 3-wire.
// [RL6] Port three pins 1, 2, 4 and 5 with select 1 map to fixed serial signals.
// [RL7] Low analog bits 5,6,7 take port three pins 0,6,7; driver and buffer off.
// [RL8] High analog bits 4,5,6 take port four pins 3,4,5; driver and buffer off.
// [RL9] Port three pins 6 and 7 have no digital peripheral function.
// [RL10] Port four pins 0 to 2 select 1: capture A in, or unit output.
// [RL11] Port four pins 3 and 4 select 1: capture B in, or unit output.
// [RL12] Port four pin 5 select 1 drives unit 2 output; no input function.
// [RL13] After any reset every pin but port two pin 7 is general I/O.
// [RL14] Reset clears direction, select, analog bits; port two select bit 7 sets.
`timescale 1ns/1ps
module port_pin_function_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic powerUpClearReset_n,
    input wire logic controlWrite,
    input wire logic [2:0] controlIndex,
    input wire logic [7:0] controlData,
    input wire logic [7:0] portTwoOutput,
    input wire logic [7:0] portThreeOutput,
    input wire logic [7:0] portFourOutput,
    input wire logic [7:0] portThreeIn,
    input wire logic [7:0] portFourIn,
    input wire logic portTwoHighIn,
    input wire logic crystalOutput,
    input wire logic serialAClockOut,
    input wire logic serialAClockOe,
    input wire logic serialAClockUsed,
    input wire logic serialBSlaveEnableOut,
    input wire logic serialBSlaveEnableOe,
    input wire logic serialBClockOut,
    input wire logic serialBClockOe,
    input wire logic serialBClockUsed,
    input wire logic serialASlaveEnableOut,
    input wire logic serialASlaveEnableOe,
    input wire logic serialBDataOut,
    input wire logic serialBDataOutOe,
    input wire logic serialBDataIn,
    input wire logic serialBDataInOe,
    input wire logic serialATransmit,
    input wire logic serialATransmitOe,
    input wire logic serialAReceive,
    input wire logic serialAReceiveOe,
    input wire logic [2:0] timerBOutput,
    output logic [7:0] portTwoDirection,
    output logic [7:0] portTwoFunctionSelect,
    output logic [7:0] portThreeDirection,
    output logic [7:0] portThreeFunctionSelect,
    output logic [7:0] portFourDirection,
    output logic [7:0] portFourFunctionSelect,
    output logic [7:0] analogEnableLow,
    output logic [7:0] analogEnableHigh,
    output logic portTwoHighOut,
    output logic portTwoHighOe,
    output logic portTwoHighData,
    output logic [7:0] portThreeOut,
    output logic [7:0] portThreeOe,
    output logic [7:0] portThreeBufferOn,
    output logic [7:0] portThreeData,
    output logic [7:0] portFourOut,
    output logic [7:0] portFourOe,
    output logic [7:0] portFourBufferOn,
    output logic [7:0] portFourData,
    output logic [7:0] serialPinIn,
    output logic serialBForceThreeWire,
    output logic serialAForceThreeWire,
    output logic [2:0] captureInputA,
    output logic [1:0] captureInputB,
    output logic [2:0] converterSelect
);
    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic anyReset_n;
    logic [7:0] regValue [0:7];
    localparam logic [7:0] RESET_TABLE [0:7] = '{
        pin_mux_pkg::DIRECTION_RESET, pin_mux_pkg::P2_SELECT_RESET,
        pin_mux_pkg::DIRECTION_RESET, pin_mux_pkg::SELECT_RESET,
        pin_mux_pkg::DIRECTION_RESET, pin_mux_pkg::SELECT_RESET,
        pin_mux_pkg::ANALOG_RESET, pin_mux_pkg::ANALOG_RESET};

    // Either reset source returns every bit to its default.
    assign anyReset_n = rst_n & powerUpClearReset_n; // RL13

    // Index 0..7: p2 dir, p2 sel, p3 dir, p3 sel, p4 dir, p4 sel, analog low, high.
    for (genvar i = 0; i < 8; i++) begin : g_reg
        control_reg #(.WIDTH(8), .RESET_VALUE(RESET_TABLE[i])) ctrl ( // RL14 RL2
            .clk(clk),
            .rst_n(anyReset_n),
            .writeEnable(controlWrite && (controlIndex == 3'(i))),
            .writeData(controlData),
            .value(regValue[i])
        );
    end

    // Register contents go out unchanged so software can read back what it wrote.
    assign portTwoDirection = regValue[0];
    assign portTwoFunctionSelect = regValue[1];
    assign portThreeDirection = regValue[2];
    assign portThreeFunctionSelect = regValue[3];
    assign portFourDirection = regValue[4];
    assign portFourFunctionSelect = regValue[5];
    assign analogEnableLow = regValue[6];
    assign analogEnableHigh = regValue[7];

    // ****************************************************************
    // Pin routing
    // ****************************************************************
    logic [7:0] p3Analog;
    logic [7:0] p4Analog;
    logic [7:0] p3SerialOut;
    logic [7:0] p3SerialOe;
    logic [7:0] p4TimerOut;

    // Analog enables per pin; only the converter pins carry one, the rest stay digital.
    always_comb begin
        p3Analog = 8'h00;
        p4Analog = 8'h00;
        p3Analog[pin_mux_pkg::P3_CONVERTER_PIN0] =
            analogEnableLow[pin_mux_pkg::P3_ANALOG_BIT0]; // RL7
        p3Analog[pin_mux_pkg::P3_CONVERTER_PIN6] =
            analogEnableLow[pin_mux_pkg::P3_ANALOG_BIT6]; // RL7
        p3Analog[pin_mux_pkg::P3_CONVERTER_PIN7] =
            analogEnableLow[pin_mux_pkg::P3_ANALOG_BIT7]; // RL7
        p4Analog[3] = analogEnableHigh[pin_mux_pkg::P4_ANALOG_BIT3]; // RL8
        p4Analog[4] = analogEnableHigh[pin_mux_pkg::P4_ANALOG_BIT4]; // RL8
        p4Analog[5] = analogEnableHigh[pin_mux_pkg::P4_ANALOG_BIT5]; // RL8
        converterSelect = {p3Analog[7], p3Analog[6], p3Analog[0]};
    end

    // Serial signals per port three pin; the serial block owns direction.
    always_comb begin
        p3SerialOut = 8'h00;
        p3SerialOe = 8'h00;
        // Pin 0: channel A clock wins over channel B slave enable.
        if (serialAClockUsed) begin // RL4
            p3SerialOut[0] = serialAClockOut;
            p3SerialOe[0] = serialAClockOe; // RL3
        end else begin
            p3SerialOut[0] = serialBSlaveEnableOut;
            p3SerialOe[0] = serialBSlaveEnableOe; // RL3
        end
        p3SerialOut[1] = serialBDataOut; // RL6
        p3SerialOe[1] = serialBDataOutOe;
        p3SerialOut[2] = serialBDataIn; // RL6
        p3SerialOe[2] = serialBDataInOe;
        // Pin 3: channel B clock wins over channel A slave enable.
        if (serialBClockUsed) begin // RL5
            p3SerialOut[3] = serialBClockOut;
            p3SerialOe[3] = serialBClockOe;
        end else begin
            p3SerialOut[3] = serialASlaveEnableOut;
            p3SerialOe[3] = serialASlaveEnableOe;
        end
        p3SerialOut[4] = serialATransmit; // RL6
        p3SerialOe[4] = serialATransmitOe;
        p3SerialOut[5] = serialAReceive; // RL6
        p3SerialOe[5] = serialAReceiveOe;
    end

    // Forcing to 3-wire holds while the clock function claims the shared pin.
    assign serialBForceThreeWire = portThreeFunctionSelect[0] & ~p3Analog[0]
        & serialAClockUsed; // RL4
    assign serialAForceThreeWire = portThreeFunctionSelect[3] & serialBClockUsed; // RL5

    // Port two pin 7: crystal output whenever selected, else general I/O.
    always_comb begin
        if (portTwoFunctionSelect[pin_mux_pkg::CRYSTAL_PIN]) begin // RL2
            portTwoHighOut = crystalOutput;
            portTwoHighOe = 1'b1;
            portTwoHighData = 1'b0;
        end else begin // RL1
            portTwoHighOut = portTwoOutput[pin_mux_pkg::CRYSTAL_PIN];
            portTwoHighOe = portTwoDirection[pin_mux_pkg::CRYSTAL_PIN];
            portTwoHighData = portTwoHighIn;
        end
    end

    // Port three: analog, then serial select, then general I/O.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (p3Analog[i]) begin // RL7
                portThreeOut[i] = 1'b0;
                portThreeOe[i] = 1'b0;
                portThreeBufferOn[i] = 1'b0;
            end else if (portThreeFunctionSelect[i] && i <= pin_mux_pkg::P3_SERIAL_HIGH) begin
                portThreeOut[i] = p3SerialOut[i]; // RL3 RL6
                portThreeOe[i] = p3SerialOe[i];
                portThreeBufferOn[i] = 1'b1;
            end else begin // RL1 RL9
                portThreeOut[i] = portThreeOutput[i];
                portThreeOe[i] = portThreeDirection[i];
                portThreeBufferOn[i] = 1'b1;
            end
        end
        portThreeData = portThreeIn & portThreeBufferOn;
        serialPinIn = portThreeData & portThreeFunctionSelect & 8'h3f;
    end

    // Port four: analog, then timer select, then general I/O.
    always_comb begin
        p4TimerOut = {2'b00, timerBOutput[2], timerBOutput[1], timerBOutput[0],
            timerBOutput};
        for (int i = 0; i < 8; i++) begin
            if (p4Analog[i]) begin // RL8
                portFourOut[i] = 1'b0;
                portFourOe[i] = 1'b0;
                portFourBufferOn[i] = 1'b0;
            end else if (portFourFunctionSelect[i] && i <= 5) begin // RL10 RL11 RL12
                portFourOut[i] = p4TimerOut[i];
                portFourOe[i] = portFourDirection[i];
                portFourBufferOn[i] = 1'b1;
            end else begin // RL1
                portFourOut[i] = portFourOutput[i];
                portFourOe[i] = portFourDirection[i];
                portFourBufferOn[i] = 1'b1;
            end
        end
        portFourData = portFourIn & portFourBufferOn;
    end

    // Capture inputs only while selected as timer inputs; pin 5 feeds none.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            captureInputA[i] = portFourFunctionSelect[i] & ~portFourDirection[i]
                & portFourIn[i]; // RL10
        end
        for (int i = 0; i < 2; i++) begin
            captureInputB[i] = portFourFunctionSelect[i+3] & ~portFourDirection[i+3]
                & ~p4Analog[i+3] & portFourIn[i+3]; // RL11 RL12
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    analog_low_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        p3Analog[0] |-> !portThreeOe[0] && !portThreeBufferOn[0]) // RL7
        else $error("Converter pin still driven.");
    analog_high_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        analogEnableHigh[5] |-> !portFourOe[4] && !portFourData[4]) // RL8
        else $error("Port four converter pin not isolated.");
    crystal_reset_a: assert property (@(posedge clk) $rose(rst_n)
        |-> portTwoFunctionSelect == 8'h80 && portThreeFunctionSelect == 8'h00) // RL14
        else $error("Wrong select reset value.");
    crystal_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        portTwoFunctionSelect[7] |-> portTwoHighOe && portTwoHighOut == crystalOutput) // RL2
        else $error("Crystal output not on pin.");
    gpio_direction_a: assert property (@(posedge clk) disable iff (!rst_n)
        !portThreeFunctionSelect[4] |-> portThreeOe[4] == portThreeDirection[4]) // RL1
        else $error("General I/O direction ignored.");
    clock_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
        portThreeFunctionSelect[0] && !p3Analog[0] && serialAClockUsed
        |-> serialBForceThreeWire && portThreeOut[0] == serialAClockOut) // RL4
        else $error("Channel A clock lost priority.");
    b_clock_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
        portThreeFunctionSelect[3] && serialBClockUsed
        |-> serialAForceThreeWire && portThreeOe[3] == serialBClockOe) // RL5
        else $error("Channel B clock lost priority.");
    no_function_a: assert property (@(posedge clk) disable iff (!rst_n)
        !p3Analog[6] |-> portThreeOe[6] == portThreeDirection[6]) // RL9
        else $error("Pin six took a peripheral function.");
    timer_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        portFourFunctionSelect[5] && portFourDirection[5] && !p4Analog[5]
        |-> portFourOut[5] == timerBOutput[2]) // RL12
        else $error("Unit two output missing on pin five.");
endmodule

// ===== pkg/pin_mux_pkg.sv
// Constants shared by the pin function multiplexer files.
package pin_mux_pkg;
    // ****************************************************************
    // Pin counts and indices
    // ****************************************************************
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned CRYSTAL_PIN = 7;
    localparam int unsigned P3_SERIAL_LOW = 1;
    localparam int unsigned P3_SERIAL_HIGH = 5;
    localparam int unsigned P3_CONVERTER_PIN0 = 0;
    localparam int unsigned P3_CONVERTER_PIN6 = 6;
    localparam int unsigned P3_CONVERTER_PIN7 = 7;
    localparam int unsigned P3_ANALOG_BIT0 = 5;
    localparam int unsigned P3_ANALOG_BIT6 = 6;
    localparam int unsigned P3_ANALOG_BIT7 = 7;
    localparam int unsigned P4_ANALOG_BIT3 = 4;
    localparam int unsigned P4_ANALOG_BIT4 = 5;
    localparam int unsigned P4_ANALOG_BIT5 = 6;
    // ****************************************************************
    // Reset values of the control registers
    // ****************************************************************
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] P2_SELECT_RESET = 8'h80;
    localparam logic [7:0] ANALOG_RESET = 8'h00;
endpackage

// ===== rtl/control_reg.sv
// One eight-bit control register with write enable and reset value.
`timescale 1ns/1ps
module control_reg #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic writeEnable,
    input wire logic [WIDTH-1:0] writeData,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;

    // Next value follows a write, otherwise holds.
    always_comb begin
        value_next = writeEnable ? writeData : value_reg;
    end

    // Reset loads only the constant reset value.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    // The output comes straight from the flip-flops, so it never glitches.
    assign value = value_reg;
endmodule

// ===== dv/peripheral_model.sv
// Behavioural model of the serial, timer and oscillator peripherals beside the pin mux.
`timescale 1ns/1ps
module peripheral_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic crystalOutput,
    output logic [15:0] serialDrive,
    output logic [2:0] timerBOutput
);
    logic [15:0] patternReg;
    logic [15:0] patternNext;
    // A pattern that moves every cycle, so a stale or crossed route seldom matches by luck.
    always_comb begin
        patternNext = {patternReg[14:0], patternReg[15] ^ patternReg[13] ^ patternReg[4]};
    end
    // Register the pattern; it restarts from a fixed nonzero seed on reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            patternReg <= 16'h5a3c;
        end else begin
            patternReg <= patternNext;
        end
    end
    // Serial pairs are {enable, level} from bit 0 upwards, in the order the bench expects.
    assign serialDrive = patternReg;
    assign crystalOutput = patternReg[7] ^ patternReg[2];
    assign timerBOutput = patternReg[11:9] ^ patternReg[5:3];
endmodule

// ===== dv/port_pin_function_select_tb.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
module port_pin_function_select_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerClear_n = 1'b1;
    logic wr = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] p2Out = 8'h96, p3Out = 8'h3c, p4Out = 8'hc3, p3In = 8'h5a, p4In = 8'ha5;
    logic p2In = 1'b1, aNeed = 1'b0, bNeed = 1'b0;
    logic crystal, out2, oe2, dat2, forceB, forceA;
    logic [15:0] ser;
    logic [2:0] tmr, capA, conv;
    logic [1:0] capB;
    logic [7:0] dir2, sel2, dir3, sel3, dir4, sel4, anLo, anHi, serIn;
    logic [7:0] out3, oe3, buf3, dat3, out4, oe4, buf4, dat4;
    int errorCnt = 0;
    int testsRun = 0;

    always #5 clk = ~clk;

    peripheral_model model_u (.clk(clk), .rst_n(rst_n), .crystalOutput(crystal),
        .serialDrive(ser), .timerBOutput(tmr));

    port_pin_function_select dut_u (.clk(clk), .rst_n(rst_n), .powerUpClearReset_n(powerClear_n),
        .controlWrite(wr), .controlIndex(idx), .controlData(wdata), .portTwoOutput(p2Out),
        .portThreeOutput(p3Out), .portFourOutput(p4Out), .portThreeIn(p3In),
        .portFourIn(p4In), .portTwoHighIn(p2In), .crystalOutput(crystal),
        .serialAClockOut(ser[0]), .serialAClockOe(ser[1]), .serialAClockUsed(aNeed),
        .serialBSlaveEnableOut(ser[2]), .serialBSlaveEnableOe(ser[3]),
        .serialBClockOut(ser[4]), .serialBClockOe(ser[5]), .serialBClockUsed(bNeed),
        .serialASlaveEnableOut(ser[6]), .serialASlaveEnableOe(ser[7]),
        .serialBDataOut(ser[8]), .serialBDataOutOe(ser[9]), .serialBDataIn(ser[10]),
        .serialBDataInOe(ser[11]), .serialATransmit(ser[12]), .serialATransmitOe(ser[13]),
        .serialAReceive(ser[14]), .serialAReceiveOe(ser[15]), .timerBOutput(tmr),
        .portTwoDirection(dir2), .portTwoFunctionSelect(sel2), .portThreeDirection(dir3),
        .portThreeFunctionSelect(sel3), .portFourDirection(dir4),
        .portFourFunctionSelect(sel4), .analogEnableLow(anLo), .analogEnableHigh(anHi),
        .portTwoHighOut(out2), .portTwoHighOe(oe2), .portTwoHighData(dat2),
        .portThreeOut(out3), .portThreeOe(oe3), .portThreeBufferOn(buf3),
        .portThreeData(dat3), .portFourOut(out4), .portFourOe(oe4), .portFourBufferOn(buf4),
        .portFourData(dat4), .serialPinIn(serIn), .serialBForceThreeWire(forceB),
        .serialAForceThreeWire(forceA), .captureInputA(capA), .captureInputB(capB),
        .converterSelect(conv));

    // Every comparison passes through here so that both counts stay honest.
    task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One register write; the new value is visible just after the second edge.
    task automatic wreg(input logic [2:0] i, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        idx <= i;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Reset contents of all eight control registers.
    task automatic regs_default();
        chk(8'h00, dir2, "p2 dir");
        chk(8'h80, sel2, "p2 sel");
        chk(8'h00, dir3, "p3 dir");
        chk(8'h00, sel3, "p3 sel");
        chk(8'h00, dir4, "p4 dir");
        chk(8'h00, sel4, "p4 sel");
        chk(8'h00, anLo, "analog low");
        chk(8'h00, anHi, "analog high");
    endtask

    // Straight out of reset the crystal owns its pin and the rest sit as inputs.
    task automatic test_reset();
        regs_default();
        chk({7'h0, crystal}, {7'h0, out2}, "crystal out");
        chk(8'h00, oe3, "p3 oe");
        chk(8'h00, oe4, "p4 oe");
        chk(p3In, dat3, "p3 data");
    endtask

    // Hand the crystal pin back and drive mixed directions on every port.
    task automatic test_gpio();
        wreg(3'h1, 8'h00);
        wreg(3'h0, 8'h80);
        wreg(3'h2, 8'ha5);
        wreg(3'h4, 8'h3c);
        chk({7'h0, p2Out[7]}, {7'h0, out2}, "p2 pin 7 out");
        chk(8'h01, {7'h0, oe2}, "p2 pin 7 oe");
        chk({7'h0, p2In}, {7'h0, dat2}, "p2 pin 7 in");
        chk(8'ha5, oe3, "p3 oe");
        chk(p3Out, out3, "p3 out");
        chk(p3In, dat3, "p3 in");
        chk(8'h3c, oe4, "p4 oe");
        chk(p4Out, out4, "p4 out");
        chk(p4In, dat4, "p4 in");
    endtask

    // Serial pins keep a leftover direction setting, which must be ignored.
    task automatic test_serial();
        logic [7:0] eo;
        logic [7:0] ee;
        wreg(3'h3, 8'h3f);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            aNeed <= k[0];
            bNeed <= k[1];
            p3In <= p3In ^ 8'h2d;
            #1;
            eo = {2'b00, ser[14], ser[12], bNeed ? ser[4] : ser[6], ser[10], ser[8],
                aNeed ? ser[0] : ser[2]};
            ee = {2'b00, ser[15], ser[13], bNeed ? ser[5] : ser[7], ser[11], ser[9],
                aNeed ? ser[1] : ser[3]};
            chk(eo, out3 & 8'h3f, "serial out");
            chk(ee, oe3 & 8'h3f, "serial oe");
            chk({2'b00, p3In[5:0]}, serIn & 8'h3f, "serial in");
            chk({6'h0, aNeed, bNeed}, {6'h0, forceB, forceA}, "three wire");
        end
    endtask

    // Timer pins as capture inputs first, then as compare outputs.
    task automatic test_timer();
        wreg(3'h5, 8'h3f);
        wreg(3'h4, 8'h00);
        chk({5'h0, p4In[2:0]}, {5'h0, capA}, "capture a");
        chk({6'h0, p4In[4:3]}, {6'h0, capB}, "capture b");
        chk(8'h00, oe4 & 8'h3f, "timer input oe");
        wreg(3'h4, 8'h3f);
        chk({2'b00, tmr, tmr}, out4 & 8'h3f, "timer out");
        chk(8'h3f, oe4 & 8'h3f, "timer oe");
    endtask

    // Analog bits must win over select and direction that would otherwise drive.
    task automatic test_analog();
        wreg(3'h3, 8'hff);
        wreg(3'h2, 8'hff);
        wreg(3'h6, 8'he0);
        wreg(3'h7, 8'h70);
        chk(8'h00, (oe3 | buf3) & 8'hc1, "p3 analog pins");
        chk(8'h07, {5'h0, conv}, "converter select");
        chk(8'h00, (oe4 | buf4) & 8'h38, "p4 analog pins");
        chk(8'h00, (dat3 | serIn) & 8'hc1, "p3 analog data");
        chk(8'h00, dat4 & 8'h38, "p4 analog data");
        wreg(3'h6, 8'h00);
        wreg(3'h3, 8'hc0);
        chk(8'h00, {5'h0, conv}, "converter released");
        chk(8'hc0, oe3 & 8'hc0, "p3 upper oe");
        chk(p3Out & 8'hc0, out3 & 8'hc0, "p3 upper out");
    endtask

    // The second reset in mid-run must restore the same defaults.
    task automatic test_power_clear();
        @(posedge clk);
        powerClear_n <= 1'b0;
        @(posedge clk);
        powerClear_n <= 1'b1;
        #1;
        regs_default();
        chk(8'h00, oe4, "p4 oe after clear");
        chk({7'h0, crystal}, {7'h0, out2}, "crystal after clear");
        chk(8'h01, {7'h0, oe2}, "crystal oe after clear");
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset for five cycles, then each scenario in turn.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        test_reset();
        test_gpio();
        test_serial();
        test_timer();
        test_analog();
        test_power_clear();
        summarize();
    end

    // The scenarios need well under a hundred cycles; this only catches a hang.
    initial begin
        #20000;
        errorCnt++;
        summarize();
    end
endmodule
